// ---- rtl/icm_timing.sv ----
// instruction cycle-count model: class, form and case in, clock and bus-cycle counts out
`timescale 1ns/1ps
`default_nettype none
`include "icm_map.svh"

// Overview of operation
// - each answer gives total clocks plus reads, prefetches, writes, all inside the total
// - worst case of arithmetic and logic ops includes next-instruction prefetch clocks
// - fetch-effective-address entries add the supplied address time to the total
// - multi-register and alternate-space alternate_space_move add the calculate-immediate-address time
// - multi-register load: 8+4n clocks, n reads; worst 9+4n with one prefetch
// - multi-register store: 4+3n clocks, n writes; worst 5+3n with one prefetch
// - control register write: 9, 12, 13 clocks; no operand cycles; worst one prefetch
// - control register read: 3, 6, 7 clocks with no operand bus cycles
// - full status register load: 8, 8, 11 clocks; worst has two prefetches
// - long peripheral-byte move to memory: four writes, 14, 17, 17 clocks
// - word peripheral-byte move to register: two reads, 10, 12, 12 clocks
// - long peripheral-byte move to register: four reads, 16, 18, 18 clocks
// - alternate-space move to register: one read, 7, 7, 8 clocks
// - register-destination add, sub, and, or, compare: 0, 2, 3 clocks
// - memory-destination add, sub, and, or, exclusive-or: one write, 3, 4, 6
// - address compare: 1 clock best, 4 clocks cache and worst
// - bounds compare: one read, 16, 18, 18 clocks
// - multiply word 25, 27, 28 clocks; multiply long 41, 43, 44
// - unsigned divide word 42, 44, 44; long 76, 78, 79 clocks
// - signed divide word 54, 56, 57; long 88, 90, 91 clocks
// - quick add to memory: one write, 3, 4, 6 clocks
// - quick load to data register: 0, 2, 3 clocks, worst one prefetch
module icm_timing (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire icm_pkg::icm_class_t req_class,
  input wire logic req_mem_form,
  input wire icm_pkg::icm_case_t req_case,
  input wire logic [4:0] req_reg_count,
  input wire logic [7:0] req_ea_cycles,
  output var logic rsp_valid_q,
  output var logic [9:0] rsp_total_q,
  output var logic [4:0] rsp_reads_q,
  output var logic [3:0] rsp_prefetch_q,
  output var logic [4:0] rsp_writes_q,
  output var icm_pkg::icm_ea_t rsp_ea_kind_q,
  output var logic rsp_err_q
);
  import icm_pkg::*;

  icm_row_t row;
  logic [6:0] per_reg;
  logic mrm_read;
  logic mrm_write;
  logic case_ok;
  logic class_ok;
  logic [9:0] total_d;
  logic [4:0] reads_d;
  logic [3:0] prefetch_d;
  logic [4:0] writes_d;

  // table lookup by class and addressing form
  always_comb
  begin
    row = `ICM_ROW_EMPTY;
    class_ok = 1'b1;
    case (req_class)
      ICM_EXCHANGE: row = `ICM_ROW_EXCHANGE;
      ICM_CTL_READ: row = `ICM_ROW_CTL_READ;
      ICM_CTL_WRITE: row = `ICM_ROW_CTL_WRITE;
      ICM_PSW_MOVE: row = req_mem_form ? `ICM_ROW_PSW_MEM : `ICM_ROW_PSW_REG;
      ICM_CCR_LOAD: row = `ICM_ROW_CCR_LOAD;
      ICM_SR_LOAD: row = `ICM_ROW_SR_LOAD;
      ICM_MRM: row = req_mem_form ? `ICM_ROW_MRM_STORE : `ICM_ROW_MRM_LOAD;
      ICM_PBM_WORD: row = req_mem_form ? `ICM_ROW_PBM_W_TO_MEM : `ICM_ROW_PBM_W_TO_REG;
      ICM_PBM_LONG: row = req_mem_form ? `ICM_ROW_PBM_L_TO_MEM : `ICM_ROW_PBM_L_TO_REG;
      ICM_ASM: row = req_mem_form ? `ICM_ROW_ASM_STORE : `ICM_ROW_ASM_LOAD;
      ICM_USP_MOVE: row = `ICM_ROW_USP_MOVE;
      ICM_SWAP: row = `ICM_ROW_SWAP;
      ICM_ALU: row = req_mem_form ? `ICM_ROW_ALU_MEM : `ICM_ROW_ALU_REG;
      ICM_ADDR_CMP: row = `ICM_ROW_ADDR_CMP;
      ICM_BOUNDS_CMP: row = `ICM_ROW_BOUNDS_CMP;
      ICM_MULTIPLY_WORD: row = `ICM_ROW_MULTIPLY_WORD;
      ICM_MULTIPLY_LONG: row = `ICM_ROW_MULTIPLY_LONG;
      ICM_UNSIGNED_DIVIDE_WORD: row = `ICM_ROW_UNSIGNED_DIVIDE_WORD;
      ICM_UNSIGNED_DIVIDE_LONG: row = `ICM_ROW_UNSIGNED_DIVIDE_LONG;
      ICM_SIGNED_DIVIDE_WORD: row = `ICM_ROW_SIGNED_DIVIDE_WORD;
      ICM_SIGNED_DIVIDE_LONG: row = `ICM_ROW_SIGNED_DIVIDE_LONG;
      ICM_QUICK_LOAD: row = `ICM_ROW_QUICK_LOAD;
      ICM_QUICK_ADD: row = req_mem_form ? `ICM_ROW_QUICK_MEM : `ICM_ROW_QUICK_REG;
      ICM_IMM_ALU: row = req_mem_form ? `ICM_ROW_IMM_MEM : `ICM_ROW_IMM_REG;
      default: class_ok = 1'b0;
    endcase
  end

  // multi-register alternate_space_move scale with the register count
  assign mrm_read = (req_class == ICM_MRM) && !req_mem_form;
  assign mrm_write = (req_class == ICM_MRM) && req_mem_form;

  always_comb
  begin
    per_reg = 7'h00;
    if (mrm_read)
    begin
      per_reg = `ICM_MRM_LOAD_PER;
    end
    else if (mrm_write)
    begin
      per_reg = `ICM_MRM_STORE_PER;
    end
  end

  // pick the case column; prefetches appear only in the worst case
  always_comb
  begin
    total_d = 10'h000;
    prefetch_d = 4'h0;
    case_ok = 1'b1;
    case (req_case)
      ICM_CASE_BEST: total_d = {2'b00, row.best};
      ICM_CASE_CACHE: total_d = {2'b00, row.cache};
      ICM_CASE_WORST:
      begin
        total_d = {2'b00, row.worst};
        prefetch_d = row.wpref;
      end
      default: case_ok = 1'b0;
    endcase
    total_d = total_d + 10'(per_reg * {2'b00, req_reg_count});
    if (row.ea != ICM_EA_NONE)
    begin
      total_d = total_d + {2'b00, req_ea_cycles};
    end
  end

  // bus-cycle counts, already part of the total
  always_comb
  begin
    reads_d = mrm_read ? req_reg_count : {1'b0, row.reads};
    writes_d = mrm_write ? req_reg_count : {1'b0, row.writes};
  end

  // answer strobe, one per request
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= req_valid;
    end
  end

  // error on an unknown class, case or oversized register list
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_err_q <= 1'b0;
    end
    else if (req_valid)
    begin
      rsp_err_q <= !case_ok || !class_ok || (req_reg_count > `ICM_MAX_REGS);
    end
  end

  // counts, held until the next request
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_total_q <= 10'h000;
      rsp_reads_q <= 5'h00;
      rsp_prefetch_q <= 4'h0;
      rsp_writes_q <= 5'h00;
      rsp_ea_kind_q <= ICM_EA_NONE;
    end
    else if (req_valid)
    begin
      rsp_total_q <= total_d;
      rsp_reads_q <= reads_d;
      rsp_prefetch_q <= prefetch_d;
      rsp_writes_q <= writes_d;
      rsp_ea_kind_q <= row.ea;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  function automatic logic hit(icm_class_t c, logic m, icm_case_t k);
    hit = req_valid && req_class == c && req_mem_form == m && req_case == k;
  endfunction : hit

  chk_answer_strobe: assert property (
    req_valid |=> rsp_valid_q)
    else $error("answer strobe missing after request");
  chk_strobe_drops: assert property (
    !req_valid |=> !rsp_valid_q)
    else $error("answer strobe without request");
  chk_mrm_load_sum: assert property (
    hit(ICM_MRM, 1'b0, ICM_CASE_WORST) |=> rsp_total_q ==
      10'h009 + 10'(4 * $past(req_reg_count)) + {2'h0, $past(req_ea_cycles)}
      && rsp_reads_q == $past(req_reg_count) && rsp_prefetch_q == 4'h1)
    else $error("multi-register load worst count wrong");
  chk_mrm_store_sum: assert property (
    hit(ICM_MRM, 1'b1, ICM_CASE_BEST) |=> rsp_total_q ==
      10'h004 + 10'(3 * $past(req_reg_count)) + {2'h0, $past(req_ea_cycles)}
      && rsp_writes_q == $past(req_reg_count) && rsp_prefetch_q == 4'h0)
    else $error("multi-register store best count wrong");
  chk_ctl_write_worst: assert property (
    hit(ICM_CTL_WRITE, 1'b0, ICM_CASE_WORST) |=> rsp_total_q == 10'h00D
      && rsp_reads_q == 5'h00 && rsp_writes_q == 5'h00 && rsp_prefetch_q == 4'h1)
    else $error("control write worst count wrong");
  chk_ctl_read_cache: assert property (
    hit(ICM_CTL_READ, 1'b0, ICM_CASE_CACHE) |=> rsp_total_q == 10'h006)
    else $error("control read cache count wrong");
  chk_sr_load_worst: assert property (
    hit(ICM_SR_LOAD, 1'b0, ICM_CASE_WORST) |=> rsp_prefetch_q == 4'h2
      && rsp_total_q == 10'h00B + {2'h0, $past(req_ea_cycles)})
    else $error("status register load worst count wrong");
  chk_pbm_long_writes: assert property (
    hit(ICM_PBM_LONG, 1'b1, ICM_CASE_BEST) |=> rsp_writes_q == 5'h04
      && rsp_total_q == 10'h00E)
    else $error("long peripheral move to memory wrong");
  chk_pbm_word_reads: assert property (
    hit(ICM_PBM_WORD, 1'b0, ICM_CASE_CACHE) |=> rsp_reads_q == 5'h02
      && rsp_total_q == 10'h00C)
    else $error("word peripheral move to register wrong");
  chk_pbm_long_reads: assert property (
    hit(ICM_PBM_LONG, 1'b0, ICM_CASE_BEST) |=> rsp_reads_q == 5'h04
      && rsp_total_q == 10'h010)
    else $error("long peripheral move to register wrong");
  chk_asm_load_worst: assert property (
    hit(ICM_ASM, 1'b0, ICM_CASE_WORST) |=> rsp_reads_q == 5'h01
      && rsp_total_q == 10'h008 + {2'h0, $past(req_ea_cycles)}
      && rsp_ea_kind_q == ICM_EA_CALC_IMM)
    else $error("alternate-space load wrong");
  chk_alu_reg_best: assert property (
    hit(ICM_ALU, 1'b0, ICM_CASE_BEST) |=> rsp_total_q == {2'h0, $past(req_ea_cycles)})
    else $error("register alu best count wrong");
  chk_alu_mem_worst: assert property (
    hit(ICM_ALU, 1'b1, ICM_CASE_WORST) |=> rsp_writes_q == 5'h01
      && rsp_prefetch_q == 4'h1 && rsp_total_q == 10'h006 + {2'h0, $past(req_ea_cycles)})
    else $error("memory alu worst count wrong");
  chk_addr_cmp_best: assert property (
    hit(ICM_ADDR_CMP, 1'b0, ICM_CASE_BEST) ##1 rst_n |-> rsp_total_q ==
      10'h001 + {2'h0, $past(req_ea_cycles)})
    else $error("address compare best count wrong");
  chk_bounds_cmp: assert property (
    hit(ICM_BOUNDS_CMP, 1'b0, ICM_CASE_CACHE) |=> rsp_reads_q == 5'h01
      && rsp_ea_kind_q == ICM_EA_FETCH_IMM)
    else $error("bounds compare wrong");
  chk_mul_long: assert property (
    hit(ICM_MULTIPLY_LONG, 1'b0, ICM_CASE_WORST)
      |=> rsp_total_q == 10'h02C + {2'h0, $past(req_ea_cycles)})
    else $error("long multiply worst count wrong");
  chk_divu_word: assert property (
    hit(ICM_UNSIGNED_DIVIDE_WORD, 1'b0, ICM_CASE_BEST)
      |=> rsp_total_q == 10'h02A + {2'h0, $past(req_ea_cycles)})
    else $error("unsigned word divide best count wrong");
  chk_divs_long: assert property (
    hit(ICM_SIGNED_DIVIDE_LONG, 1'b0, ICM_CASE_CACHE)
      |=> rsp_total_q == 10'h05A + {2'h0, $past(req_ea_cycles)})
    else $error("signed long divide cache count wrong");
  chk_quick_add_mem: assert property (
    hit(ICM_QUICK_ADD, 1'b1, ICM_CASE_CACHE) |=> rsp_writes_q == 5'h01
      && rsp_total_q == 10'h004 + {2'h0, $past(req_ea_cycles)})
    else $error("quick add to memory wrong");
  chk_quick_load: assert property (
    hit(ICM_QUICK_LOAD, 1'b0, ICM_CASE_WORST) |=> rsp_total_q == 10'h003
      && rsp_prefetch_q == 4'h1 && rsp_ea_kind_q == ICM_EA_NONE)
    else $error("quick load worst count wrong");
  chk_no_prefetch_early: assert property (
    req_valid && req_case != ICM_CASE_WORST |=> rsp_prefetch_q == 4'h0)
    else $error("prefetch reported outside worst case");
  chk_counts_held: assert property (
    !req_valid |=> $stable(rsp_total_q) && $stable(rsp_reads_q) && $stable(rsp_writes_q))
    else $error("counts changed without request");
  chk_ctl_write_best: assert property (
    hit(ICM_CTL_WRITE, 1'b0, ICM_CASE_BEST) |=> rsp_total_q == 10'h009)
    else $error("control write best count wrong");
  chk_ctl_read_worst: assert property (
    hit(ICM_CTL_READ, 1'b0, ICM_CASE_WORST) |=> rsp_total_q == 10'h007
      && rsp_reads_q == 5'h00 && rsp_writes_q == 5'h00 && rsp_prefetch_q == 4'h1)
    else $error("control read worst count wrong");
  chk_sr_load_cache: assert property (
    hit(ICM_SR_LOAD, 1'b0, ICM_CASE_CACHE) |=> rsp_prefetch_q == 4'h0
      && rsp_total_q == 10'h008 + {2'h0, $past(req_ea_cycles)})
    else $error("status register load cache count wrong");
  chk_mrm_load_best: assert property (
    hit(ICM_MRM, 1'b0, ICM_CASE_BEST) |=> rsp_total_q ==
      10'h008 + 10'(4 * $past(req_reg_count)) + {2'h0, $past(req_ea_cycles)}
      && rsp_reads_q == $past(req_reg_count) && rsp_writes_q == 5'h00)
    else $error("multi-register load best count wrong");
  chk_mrm_store_worst: assert property (
    hit(ICM_MRM, 1'b1, ICM_CASE_WORST) |=> rsp_total_q ==
      10'h005 + 10'(3 * $past(req_reg_count)) + {2'h0, $past(req_ea_cycles)}
      && rsp_writes_q == $past(req_reg_count) && rsp_prefetch_q == 4'h1)
    else $error("multi-register store worst count wrong");
  chk_pbm_long_mem_worst: assert property (
    hit(ICM_PBM_LONG, 1'b1, ICM_CASE_WORST) |=> rsp_writes_q == 5'h04
      && rsp_total_q == 10'h011 && rsp_prefetch_q == 4'h1)
    else $error("long peripheral move to memory worst wrong");
  chk_pbm_long_reg_worst: assert property (
    hit(ICM_PBM_LONG, 1'b0, ICM_CASE_WORST) |=> rsp_reads_q == 5'h04
      && rsp_total_q == 10'h012 && rsp_prefetch_q == 4'h1)
    else $error("long peripheral move to register worst wrong");
  chk_asm_load_best: assert property (
    hit(ICM_ASM, 1'b0, ICM_CASE_BEST) |=> rsp_reads_q == 5'h01
      && rsp_total_q == 10'h007 + {2'h0, $past(req_ea_cycles)})
    else $error("alternate-space load best wrong");
  chk_asm_store_worst: assert property (
    hit(ICM_ASM, 1'b1, ICM_CASE_WORST) |=> rsp_ea_kind_q == ICM_EA_CALC_IMM
      && rsp_writes_q == 5'h01 && rsp_total_q == 10'h007 + {2'h0, $past(req_ea_cycles)})
    else $error("alternate-space store worst wrong");
  chk_alu_reg_worst: assert property (
    hit(ICM_ALU, 1'b0, ICM_CASE_WORST) |=> rsp_prefetch_q == 4'h1
      && rsp_total_q == 10'h003 + {2'h0, $past(req_ea_cycles)})
    else $error("register alu worst count wrong");
  chk_alu_mem_best: assert property (
    hit(ICM_ALU, 1'b1, ICM_CASE_BEST) |=> rsp_writes_q == 5'h01
      && rsp_total_q == 10'h003 + {2'h0, $past(req_ea_cycles)})
    else $error("memory alu best count wrong");
  chk_divu_long_worst: assert property (
    hit(ICM_UNSIGNED_DIVIDE_LONG, 1'b0, ICM_CASE_WORST) |=> rsp_prefetch_q == 4'h1
      && rsp_total_q == 10'h04F + {2'h0, $past(req_ea_cycles)})
    else $error("unsigned long divide worst count wrong");
  chk_quick_add_best: assert property (
    hit(ICM_QUICK_ADD, 1'b1, ICM_CASE_BEST) |=> rsp_writes_q == 5'h01
      && rsp_total_q == 10'h003 + {2'h0, $past(req_ea_cycles)})
    else $error("quick add to memory best wrong");
  chk_quick_load_best: assert property (
    hit(ICM_QUICK_LOAD, 1'b0, ICM_CASE_BEST) |=> rsp_total_q == 10'h000)
    else $error("quick load best count wrong");
  chk_fetch_kind: assert property (
    hit(ICM_CCR_LOAD, 1'b0, ICM_CASE_BEST) |=> rsp_ea_kind_q == ICM_EA_FETCH
      && rsp_total_q == 10'h004 + {2'h0, $past(req_ea_cycles)})
    else $error("fetch address time not added");
  chk_bus_in_total: assert property (
    rsp_valid_q && !rsp_err_q
      |-> rsp_total_q >= rsp_reads_q + rsp_prefetch_q + rsp_writes_q)
    else $error("bus cycles exceed total clocks");

endmodule : icm_timing
`default_nettype wire

// ---- rtl/icm_map.svh ----
// cycle-count table rows and limits for the instruction timing model
`ifndef ICM_MAP_SVH
`define ICM_MAP_SVH

// row layout: best, cache, worst, reads, worst prefetches, writes, address add-on kind
`define ICM_ROW_EXCHANGE     '{8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_CTL_READ     '{8'h03, 8'h06, 8'h07, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_CTL_WRITE    '{8'h09, 8'h0C, 8'h0D, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_PSW_REG      '{8'h01, 8'h04, 8'h05, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_PSW_MEM      '{8'h05, 8'h05, 8'h07, 4'h0, 4'h1, 4'h1, ICM_EA_CALC}
`define ICM_ROW_CCR_LOAD     '{8'h04, 8'h04, 8'h05, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_SR_LOAD      '{8'h08, 8'h08, 8'h0B, 4'h0, 4'h2, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_MRM_LOAD     '{8'h08, 8'h08, 8'h09, 4'h0, 4'h1, 4'h0, ICM_EA_CALC_IMM}
`define ICM_ROW_MRM_STORE    '{8'h04, 8'h04, 8'h05, 4'h0, 4'h1, 4'h0, ICM_EA_CALC_IMM}
`define ICM_ROW_PBM_W_TO_MEM '{8'h08, 8'h0B, 8'h0B, 4'h0, 4'h1, 4'h2, ICM_EA_NONE}
`define ICM_ROW_PBM_W_TO_REG '{8'h0A, 8'h0C, 8'h0C, 4'h2, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_PBM_L_TO_MEM '{8'h0E, 8'h11, 8'h11, 4'h0, 4'h1, 4'h4, ICM_EA_NONE}
`define ICM_ROW_PBM_L_TO_REG '{8'h10, 8'h12, 8'h12, 4'h4, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_ASM_LOAD     '{8'h07, 8'h07, 8'h08, 4'h1, 4'h1, 4'h0, ICM_EA_CALC_IMM}
`define ICM_ROW_ASM_STORE    '{8'h05, 8'h05, 8'h07, 4'h0, 4'h1, 4'h1, ICM_EA_CALC_IMM}
`define ICM_ROW_USP_MOVE     '{8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_SWAP         '{8'h01, 8'h04, 8'h04, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_ALU_REG      '{8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_ALU_MEM      '{8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 4'h1, ICM_EA_FETCH}
`define ICM_ROW_ADDR_CMP     '{8'h01, 8'h04, 8'h04, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_BOUNDS_CMP   '{8'h10, 8'h12, 8'h12, 4'h1, 4'h1, 4'h0, ICM_EA_FETCH_IMM}
`define ICM_ROW_MULTIPLY_WORD        '{8'h19, 8'h1B, 8'h1C, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_MULTIPLY_LONG        '{8'h29, 8'h2B, 8'h2C, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH_IMM}
`define ICM_ROW_UNSIGNED_DIVIDE_WORD       '{8'h2A, 8'h2C, 8'h2C, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_UNSIGNED_DIVIDE_LONG       '{8'h4C, 8'h4E, 8'h4F, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH_IMM}
`define ICM_ROW_SIGNED_DIVIDE_WORD       '{8'h36, 8'h38, 8'h39, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH}
`define ICM_ROW_SIGNED_DIVIDE_LONG       '{8'h58, 8'h5A, 8'h5B, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH_IMM}
`define ICM_ROW_QUICK_LOAD   '{8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_QUICK_REG    '{8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0, ICM_EA_NONE}
`define ICM_ROW_QUICK_MEM    '{8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 4'h1, ICM_EA_FETCH}
`define ICM_ROW_IMM_REG      '{8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0, ICM_EA_FETCH_IMM}
`define ICM_ROW_IMM_MEM      '{8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 4'h1, ICM_EA_FETCH_IMM}
`define ICM_ROW_EMPTY        '{8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 4'h0, ICM_EA_NONE}

// clocks added per register of a multi-register move
`define ICM_MRM_LOAD_PER 7'h04
`define ICM_MRM_STORE_PER 7'h03
// largest register list
`define ICM_MAX_REGS 5'h10

`endif

// ---- rtl/icm_pkg.sv ----
// types of the instruction timing model
package icm_pkg;

  typedef enum logic [4:0] {
    ICM_EXCHANGE = 5'b00000,
    ICM_CTL_READ = 5'b00001,
    ICM_CTL_WRITE = 5'b00010,
    ICM_PSW_MOVE = 5'b00011,
    ICM_CCR_LOAD = 5'b00100,
    ICM_SR_LOAD = 5'b00101,
    ICM_MRM = 5'b00110,
    ICM_PBM_WORD = 5'b00111,
    ICM_PBM_LONG = 5'b01000,
    ICM_ASM = 5'b01001,
    ICM_USP_MOVE = 5'b01010,
    ICM_SWAP = 5'b01011,
    ICM_ALU = 5'b01100,
    ICM_ADDR_CMP = 5'b01101,
    ICM_BOUNDS_CMP = 5'b01110,
    ICM_MULTIPLY_WORD = 5'b01111,
    ICM_MULTIPLY_LONG = 5'b10000,
    ICM_UNSIGNED_DIVIDE_WORD = 5'b10001,
    ICM_UNSIGNED_DIVIDE_LONG = 5'b10010,
    ICM_SIGNED_DIVIDE_WORD = 5'b10011,
    ICM_SIGNED_DIVIDE_LONG = 5'b10100,
    ICM_QUICK_LOAD = 5'b10101,
    ICM_QUICK_ADD = 5'b10110,
    ICM_IMM_ALU = 5'b10111
  } icm_class_t;

  typedef enum logic [1:0] {
    ICM_CASE_BEST = 2'b00,
    ICM_CASE_CACHE = 2'b01,
    ICM_CASE_WORST = 2'b10
  } icm_case_t;

  typedef enum logic [2:0] {
    ICM_EA_NONE = 3'b000,
    ICM_EA_FETCH = 3'b001,
    ICM_EA_FETCH_IMM = 3'b010,
    ICM_EA_CALC = 3'b011,
    ICM_EA_CALC_IMM = 3'b100
  } icm_ea_t;

  typedef struct packed {
    logic [7:0] best;
    logic [7:0] cache;
    logic [7:0] worst;
    logic [3:0] reads;
    logic [3:0] wpref;
    logic [3:0] writes;
    icm_ea_t ea;
  } icm_row_t;

endpackage : icm_pkg

// ---- sim/icm_seq_model.sv ----
// sequencer model that presents timing requests to the cycle-count model
`timescale 1ns/1ps
`default_nettype none
module icm_seq_model (
  input wire logic mclk,
  output var logic req_valid,
  output var icm_pkg::icm_class_t req_class,
  output var logic req_mem_form,
  output var icm_pkg::icm_case_t req_case,
  output var logic [4:0] req_reg_count,
  output var logic [7:0] req_ea_cycles
);
  import icm_pkg::*;
  initial
  begin
    req_valid = 1'b0;
    req_class = ICM_EXCHANGE;
    req_mem_form = 1'b0;
    req_case = ICM_CASE_BEST;
    req_reg_count = 5'h00;
    req_ea_cycles = 8'h00;
  end
  // present one request, held through the next rising edge
  task automatic put(input icm_class_t c, input logic f, input icm_case_t k,
                     input logic [4:0] n, input logic [7:0] e);
    @(posedge mclk);
    #2;
    req_valid = 1'b1;
    req_class = c;
    req_mem_form = f;
    req_case = k;
    req_reg_count = n;
    req_ea_cycles = e;
  endtask : put
  // drop the strobe; fields show inverted junk so stale values cannot pass
  task automatic idle();
    @(posedge mclk);
    #2;
    req_valid = 1'b0;
    req_class = icm_class_t'(~req_class);
    req_mem_form = ~req_mem_form;
    req_case = icm_case_t'(~req_case);
    req_reg_count = ~req_reg_count;
    req_ea_cycles = ~req_ea_cycles;
  endtask : idle
endmodule : icm_seq_model
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the instruction cycle-count model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      err_total++; \
    end \
  end
module testbench;
  import icm_pkg::*;
  typedef struct {icm_class_t c; logic f; int b, k, w, r, p, wr; icm_ea_t ea;} icm_exp_t;
  logic mclk, rst_n, req_valid, req_mem_form, rsp_valid_q, rsp_err_q;
  icm_class_t req_class;
  icm_case_t req_case;
  logic [4:0] req_reg_count, rsp_reads_q, rsp_writes_q;
  logic [7:0] req_ea_cycles;
  logic [9:0] rsp_total_q;
  logic [3:0] rsp_prefetch_q;
  icm_ea_t rsp_ea_kind_q;
  int err_total = 0;
  int compares = 0;
  icm_exp_t tbl[30] = '{
    '{ICM_CTL_WRITE, 0, 9, 12, 13, 0, 1, 0, ICM_EA_NONE},
    '{ICM_CTL_READ, 0, 3, 6, 7, 0, 1, 0, ICM_EA_NONE},
    '{ICM_SR_LOAD, 0, 8, 8, 11, 0, 2, 0, ICM_EA_FETCH},
    '{ICM_PBM_LONG, 1, 14, 17, 17, 0, 1, 4, ICM_EA_NONE},
    '{ICM_PBM_WORD, 0, 10, 12, 12, 2, 1, 0, ICM_EA_NONE},
    '{ICM_PBM_LONG, 0, 16, 18, 18, 4, 1, 0, ICM_EA_NONE},
    '{ICM_ASM, 0, 7, 7, 8, 1, 1, 0, ICM_EA_CALC_IMM},
    '{ICM_ALU, 0, 0, 2, 3, 0, 1, 0, ICM_EA_FETCH},
    '{ICM_ALU, 1, 3, 4, 6, 0, 1, 1, ICM_EA_FETCH},
    '{ICM_ADDR_CMP, 0, 1, 4, 4, 0, 1, 0, ICM_EA_FETCH},
    '{ICM_BOUNDS_CMP, 0, 16, 18, 18, 1, 1, 0, ICM_EA_FETCH_IMM},
    '{ICM_MULTIPLY_WORD, 0, 25, 27, 28, 0, 1, 0, ICM_EA_FETCH},
    '{ICM_MULTIPLY_LONG, 0, 41, 43, 44, 0, 1, 0, ICM_EA_FETCH_IMM},
    '{ICM_UNSIGNED_DIVIDE_WORD, 0, 42, 44, 44, 0, 1, 0, ICM_EA_FETCH},
    '{ICM_UNSIGNED_DIVIDE_LONG, 0, 76, 78, 79, 0, 1, 0, ICM_EA_FETCH_IMM},
    '{ICM_SIGNED_DIVIDE_WORD, 0, 54, 56, 57, 0, 1, 0, ICM_EA_FETCH},
    '{ICM_SIGNED_DIVIDE_LONG, 0, 88, 90, 91, 0, 1, 0, ICM_EA_FETCH_IMM},
    '{ICM_QUICK_ADD, 1, 3, 4, 6, 0, 1, 1, ICM_EA_FETCH},
    '{ICM_QUICK_LOAD, 0, 0, 2, 3, 0, 1, 0, ICM_EA_NONE},
    '{ICM_IMM_ALU, 1, 3, 4, 6, 0, 1, 1, ICM_EA_FETCH_IMM},
    '{ICM_EXCHANGE, 0, 0, 2, 3, 0, 1, 0, ICM_EA_NONE},
    '{ICM_PSW_MOVE, 0, 1, 4, 5, 0, 1, 0, ICM_EA_NONE},
    '{ICM_PSW_MOVE, 1, 5, 5, 7, 0, 1, 1, ICM_EA_CALC},
    '{ICM_CCR_LOAD, 0, 4, 4, 5, 0, 1, 0, ICM_EA_FETCH},
    '{ICM_PBM_WORD, 1, 8, 11, 11, 0, 1, 2, ICM_EA_NONE},
    '{ICM_ASM, 1, 5, 5, 7, 0, 1, 1, ICM_EA_CALC_IMM},
    '{ICM_USP_MOVE, 0, 0, 2, 3, 0, 1, 0, ICM_EA_NONE},
    '{ICM_SWAP, 0, 1, 4, 4, 0, 1, 0, ICM_EA_NONE},
    '{ICM_QUICK_ADD, 0, 0, 2, 3, 0, 1, 0, ICM_EA_NONE},
    '{ICM_IMM_ALU, 0, 0, 2, 3, 0, 1, 0, ICM_EA_FETCH_IMM}};
  icm_seq_model u_seq (.mclk(mclk), .req_valid(req_valid), .req_class(req_class),
    .req_mem_form(req_mem_form), .req_case(req_case), .req_reg_count(req_reg_count),
    .req_ea_cycles(req_ea_cycles));
  icm_timing u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_class(req_class), .req_mem_form(req_mem_form), .req_case(req_case),
    .req_reg_count(req_reg_count), .req_ea_cycles(req_ea_cycles),
    .rsp_valid_q(rsp_valid_q), .rsp_total_q(rsp_total_q), .rsp_reads_q(rsp_reads_q),
    .rsp_prefetch_q(rsp_prefetch_q), .rsp_writes_q(rsp_writes_q),
    .rsp_ea_kind_q(rsp_ea_kind_q), .rsp_err_q(rsp_err_q));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic expect_rsp(input int t, r, p, w, input icm_ea_t ea, input logic err);
    `CHK(rsp_valid_q, 1'b1)
    `CHK(rsp_total_q, 10'(t))
    `CHK(rsp_reads_q, 5'(r))
    `CHK(rsp_prefetch_q, 4'(p))
    `CHK(rsp_writes_q, 5'(w))
    `CHK(rsp_ea_kind_q, ea)
    `CHK(rsp_err_q, err)
  endtask : expect_rsp
  task automatic expect_zero();
    `CHK({rsp_valid_q, rsp_total_q, rsp_reads_q, rsp_prefetch_q}, 20'h0)
    `CHK({rsp_writes_q, rsp_ea_kind_q, rsp_err_q}, 9'h0)
  endtask : expect_zero
  task automatic one(input icm_class_t c, input logic f, input icm_case_t k,
                     input logic [4:0] n, input logic [7:0] e);
    u_seq.put(c, f, k, n, e);
    u_seq.idle();
  endtask : one
  // every fixed entry in all three cases, address time added where flagged
  task automatic check_table();
    int t;
    int e;
    for (int i = 0; i < 30; i++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        e = (tbl[i].ea == ICM_EA_NONE) ? 0 : 5;
        t = ((k == 0) ? tbl[i].b : (k == 1) ? tbl[i].k : tbl[i].w) + e;
        one(tbl[i].c, tbl[i].f, icm_case_t'(k), 5'h00, 8'h05);
        expect_rsp(t, tbl[i].r, (k == 2) ? tbl[i].p : 0, tbl[i].wr, tbl[i].ea, 1'b0);
      end
    end
  endtask : check_table
  // register lists at both ends of the count, load and store
  task automatic check_multi();
    int ns[3] = '{0, 1, 16};
    int n;
    for (int i = 0; i < 3; i++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        n = ns[i];
        one(ICM_MRM, 1'b0, icm_case_t'(k), 5'(n), 8'h03);
        expect_rsp(8 + 4 * n + ((k == 2) ? 1 : 0) + 3, n, (k == 2) ? 1 : 0, 0,
                   ICM_EA_CALC_IMM, 1'b0);
        one(ICM_MRM, 1'b1, icm_case_t'(k), 5'(n), 8'h03);
        expect_rsp(4 + 3 * n + ((k == 2) ? 1 : 0) + 3, 0, (k == 2) ? 1 : 0, n,
                   ICM_EA_CALC_IMM, 1'b0);
      end
    end
  endtask : check_multi
  // requests on consecutive edges, then the answer must stand
  task automatic check_back_to_back();
    u_seq.put(ICM_MULTIPLY_WORD, 1'b0, ICM_CASE_BEST, 5'h00, 8'h05);
    u_seq.put(ICM_SIGNED_DIVIDE_LONG, 1'b0, ICM_CASE_WORST, 5'h00, 8'h07);
    expect_rsp(30, 0, 0, 0, ICM_EA_FETCH, 1'b0);
    u_seq.idle();
    expect_rsp(98, 0, 1, 0, ICM_EA_FETCH_IMM, 1'b0);
    @(posedge mclk);
    #2;
    `CHK(rsp_valid_q, 1'b0)
    `CHK(rsp_total_q, 10'd98)
  endtask : check_back_to_back
  // bad case, bad class and oversize list flag an error, a good request clears it
  task automatic check_errors();
    one(ICM_CTL_READ, 1'b0, icm_case_t'(2'b11), 5'h00, 8'h00);
    `CHK(rsp_err_q, 1'b1)
    one(icm_class_t'(5'h18), 1'b0, ICM_CASE_BEST, 5'h00, 8'h00);
    `CHK(rsp_err_q, 1'b1)
    one(ICM_MRM, 1'b0, ICM_CASE_BEST, 5'h11, 8'h00);
    `CHK(rsp_err_q, 1'b1)
    one(ICM_EXCHANGE, 1'b0, ICM_CASE_WORST, 5'h00, 8'h00);
    expect_rsp(3, 0, 1, 0, ICM_EA_NONE, 1'b0);
  endtask : check_errors
  // a reset in mid-run clears every answer at once
  task automatic check_mid_reset();
    @(posedge mclk);
    #2;
    rst_n = 1'b0;
    #1;
    expect_zero();
    @(posedge mclk);
    #2;
    rst_n = 1'b1;
    one(ICM_QUICK_LOAD, 1'b0, ICM_CASE_CACHE, 5'h00, 8'h00);
    expect_rsp(2, 0, 0, 0, ICM_EA_NONE, 1'b0);
  endtask : check_mid_reset
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #500000;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    expect_zero();
    check_table();
    check_multi();
    check_back_to_back();
    check_errors();
    check_mid_reset();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
